// file: hw/ccs_regs.vh
`ifndef CCS_REGS_VH
`define CCS_REGS_VH

`define CCS_CLK_HZ        25000000
`define CCS_CYC_PER_MS    (`CCS_CLK_HZ / 1000)
`define CCS_CYC_PER_US    (`CCS_CLK_HZ / 1000000)

`define CCS_WIN_US        1000
`define CCS_BLINK_MS      250
`define CCS_PEER_TO_MS    10
`define CCS_SWITCH_MS     50

`define CCS_OFS_CTRL      8'h00
`define CCS_OFS_THR_LO    8'h04
`define CCS_OFS_THR_HI    8'h08
`define CCS_OFS_STATUS    8'h0C
`define CCS_OFS_SUPPLY    8'h10
`define CCS_OFS_TRACK     8'h14
`define CCS_OFS_DCC       8'h18

`define CCS_CTRL_RST      32'h0000_1000
`define CCS_THR_LO_RST    32'h9C40_A410
`define CCS_THR_HI_RST    32'hE290_D6D8
`define CCS_B_BOOTDONE    0
`define CCS_B_WRITING     1
`define CCS_B_DBWR        2
`define CCS_B_TWOCOL      3
`define CCS_B_FSTBY       4
`define CCS_F_PRI         10:8
`define CCS_F_SEC         14:12

`define CCS_NREF          6
`define CCS_REF_INT       3'h7
`define CCS_EXP_EDGES     8'h08
`define CCS_EDGE_TOL      8'h01
`define CCS_TRACK_SHIFT   4
`define CCS_DCC_MAX       7'h54

`define CCS_COL_OFF       3'h0
`define CCS_COL_GREEN     3'h1
`define CCS_COL_AMBER     3'h2
`define CCS_COL_RED       3'h4
`define CCS_ROLE_OFF      2'h0
`define CCS_ROLE_GREEN    2'h1
`define CCS_ROLE_AMBER    2'h2

`endif

// file: hw/ccs_top.v
// Our own choices: the Wishbone interface to the registers and the register addresses.
`include "ccs_regs.vh"

// Contract
// - supply A green between low and high
// - supply A amber in the outer bands
// - supply A red beyond extreme thresholds
// - supply B decoded like supply A
// - two-colour variant: green inside extremes, else red
// - fault indicator steady on during reset
// - fault indicator flashes while booting or writing
// - role indicator green active, amber standby
// - role indicator blinks during database writes
// - monitor frequency of all timing inputs
// - pick recovered, building, or internal reference
// - any input may be primary or secondary
// - slow tracking loop, holdover on loss
// - alarm when either supply out of range
// - switch-over to protect card under 50 ms
// - terminate up to 84 channels
module ccs_top #(
    parameter WIN_CYC     = `CCS_WIN_US * `CCS_CYC_PER_US,
    parameter BLINK_CYC   = `CCS_BLINK_MS * `CCS_CYC_PER_MS,
    parameter PEER_TO_CYC = `CCS_PEER_TO_MS * `CCS_CYC_PER_MS
) (
    input  wire                 clk_i,
    input  wire                 rst_i,
    input  wire                 wb_cyc_i,
    input  wire                 wb_stb_i,
    input  wire                 wb_we_i,
    input  wire [7:0]           wb_adr_i,
    input  wire [3:0]           wb_sel_i,
    input  wire [31:0]          wb_dat_i,
    output reg  [31:0]          wb_dat_o,
    output reg                  wb_ack_o,
    input  wire [15:0]          supply_a_mv_i,
    input  wire [15:0]          supply_b_mv_i,
    input  wire [`CCS_NREF-1:0] ref_clk_i,
    input  wire                 peer_heartbeat_i,
    input  wire                 peer_active_i,
    input  wire                 slot_preferred_i,
    input  wire                 craft_dtr_i,
    output reg  [2:0]           supply_a_indicator_o,
    output reg  [2:0]           supply_b_indicator_o,
    output reg                  fault_indicator_o,
    output reg  [1:0]           role_indicator_o,
    output reg                  supply_alarm_o,
    output reg  [2:0]           ref_sel_o,
    output reg                  holdover_o,
    output reg                  role_active_o,
    output reg                  heartbeat_o,
    output reg                  craft_en_o,
    output reg  [6:0]           dcc_chan_count_o
);

    function [2:0] ccs_colour;
        input [15:0] v;
        input [15:0] lo;
        input [15:0] hi;
        input [15:0] elo;
        input [15:0] ehi;
        input        two;
        begin
            if (v > ehi || v < elo)
                ccs_colour = `CCS_COL_RED;
            else if (two)
                ccs_colour = `CCS_COL_GREEN;
            else if (v >= lo && v <= hi)
                ccs_colour = `CCS_COL_GREEN;
            else
                ccs_colour = `CCS_COL_AMBER;
        end
    endfunction

    function ccs_ref_ok;
        input [2:0]           idx;
        input [`CCS_NREF-1:0] ok;
        begin
            ccs_ref_ok = (idx < `CCS_NREF) ? ok[idx] : 1'b0;
        end
    endfunction

    function [31:0] ccs_merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  sel;
        integer      k;
        begin
            ccs_merge = old;
            for (k = 0; k < 4; k = k + 1)
                if (sel[k])
                    ccs_merge[k*8 +: 8] = nw[k*8 +: 8];
        end
    endfunction

    reg  [31:0] ctrl_q;
    reg  [31:0] thr_lo_q;
    reg  [31:0] thr_hi_q;
    reg  [6:0]  dcc_q;
    reg  [31:0] rdata_d;
    wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        wb_wr  = wb_req & wb_we_i;

    // register file
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q   <= `CCS_CTRL_RST;
            thr_lo_q <= `CCS_THR_LO_RST;
            thr_hi_q <= `CCS_THR_HI_RST;
            dcc_q    <= 7'h00;
        end else if (wb_wr) begin
            case (wb_adr_i)
                `CCS_OFS_CTRL:   ctrl_q   <= ccs_merge(ctrl_q, wb_dat_i, wb_sel_i);
                `CCS_OFS_THR_LO: thr_lo_q <= ccs_merge(thr_lo_q, wb_dat_i, wb_sel_i);
                `CCS_OFS_THR_HI: thr_hi_q <= ccs_merge(thr_hi_q, wb_dat_i, wb_sel_i);
                `CCS_OFS_DCC: begin
                    if (wb_sel_i[0])
                        dcc_q <= (wb_dat_i[6:0] > `CCS_DCC_MAX) ?
                                 `CCS_DCC_MAX : wb_dat_i[6:0];
                end
                default: ;
            endcase
        end
    end

    wire [15:0] lo_thr  = thr_lo_q[15:0];
    wire [15:0] elo_thr = thr_lo_q[31:16];
    wire [15:0] hi_thr  = thr_hi_q[15:0];
    wire [15:0] ehi_thr = thr_hi_q[31:16];
    wire        two_col = ctrl_q[`CCS_B_TWOCOL];

    // shared window tick
    reg  [31:0] win_cnt_q;
    wire        win_end = (win_cnt_q == WIN_CYC - 1);
    always @(posedge clk_i) begin
        if (rst_i || win_end)
            win_cnt_q <= 32'h0000_0000;
        else
            win_cnt_q <= win_cnt_q + 32'h0000_0001;
    end

    // per-reference edge counting
    wire [`CCS_NREF-1:0] ref_ok_q;
    wire [8*`CCS_NREF-1:0] ref_meas;
    genvar g;
    generate
        for (g = 0; g < `CCS_NREF; g = g + 1) begin : g_ref
            reg [2:0] sh_q;
            reg [7:0] cnt_q;
            reg [7:0] last_q;
            reg       ok_q;
            wire      rise = sh_q[1] & ~sh_q[2];
            always @(posedge clk_i) begin
                if (rst_i) begin
                    sh_q        <= 3'h0;
                    cnt_q       <= 8'h00;
                    last_q      <= 8'h00;
                    ok_q        <= 1'b0;
                end else begin
                    sh_q <= {sh_q[1:0], ref_clk_i[g]};
                    if (win_end) begin
                        last_q      <= cnt_q;
                        ok_q        <= (cnt_q >= `CCS_EXP_EDGES - `CCS_EDGE_TOL) &&
                                       (cnt_q <= `CCS_EXP_EDGES + `CCS_EDGE_TOL);
                        cnt_q       <= 8'h00;
                    end else if (rise && cnt_q != 8'hFF)
                        cnt_q <= cnt_q + 8'h01;
                end
            end
            assign ref_meas[8*g +: 8] = last_q;
            assign ref_ok_q[g]        = ok_q;
        end
    endgenerate

    // reference choice and tracking loop
    wire [2:0] pri_sel = ctrl_q[`CCS_F_PRI];
    wire [2:0] sec_sel = ctrl_q[`CCS_F_SEC];
    wire       pri_ok  = ccs_ref_ok(pri_sel, ref_ok_q);
    wire       sec_ok  = ccs_ref_ok(sec_sel, ref_ok_q);
    reg  [15:0] track_q;
    reg         locked_q;
    reg  [7:0]  sel_meas;
    reg  [16:0] trk_diff;
    always @* begin
        sel_meas = 8'h00;
        if (ref_sel_o < `CCS_NREF)
            sel_meas = ref_meas[8*ref_sel_o +: 8];
        trk_diff = {1'b0, sel_meas, 8'h00} - {1'b0, track_q};
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ref_sel_o  <= `CCS_REF_INT;
            holdover_o <= 1'b0;
            locked_q   <= 1'b0;
            track_q    <= {`CCS_EXP_EDGES, 8'h00};
        end else if (win_end) begin
            if (pri_ok) begin
                ref_sel_o  <= pri_sel;
                holdover_o <= 1'b0;
                locked_q   <= 1'b1;
            end else if (sec_ok) begin
                ref_sel_o  <= sec_sel;
                holdover_o <= 1'b0;
                locked_q   <= 1'b1;
            end else begin
                ref_sel_o  <= `CCS_REF_INT;
                holdover_o <= locked_q | holdover_o;
            end
            // frozen in holdover so the last learned rate is kept
            if (ref_sel_o != `CCS_REF_INT && ccs_ref_ok(ref_sel_o, ref_ok_q))
                track_q <= track_q + {{`CCS_TRACK_SHIFT{trk_diff[16]}},
                           trk_diff[15:`CCS_TRACK_SHIFT]};
        end
    end

    // blink timebase
    reg [31:0] blink_cnt_q;
    reg        blink_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= 1'b1;
        end else if (blink_cnt_q == BLINK_CYC - 1) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_q     <= ~blink_q;
        end else
            blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end

    // peer supervision, pins synchronised first
    reg  [2:0]  hb_sh_q;
    reg  [1:0]  pact_sh_q;
    reg  [1:0]  pref_sh_q;
    reg  [1:0]  dtr_sh_q;
    reg  [31:0] peer_to_q;
    wire        peer_lost = (peer_to_q == PEER_TO_CYC - 1);
    wire        hb_edge   = hb_sh_q[1] ^ hb_sh_q[2];
    always @(posedge clk_i) begin
        if (rst_i) begin
            hb_sh_q   <= 3'h0;
            pact_sh_q <= 2'h0;
            pref_sh_q <= 2'h0;
            dtr_sh_q  <= 2'h0;
            peer_to_q <= 32'h0000_0000;
        end else begin
            hb_sh_q   <= {hb_sh_q[1:0], peer_heartbeat_i};
            pact_sh_q <= {pact_sh_q[0], peer_active_i};
            pref_sh_q <= {pref_sh_q[0], slot_preferred_i};
            dtr_sh_q  <= {dtr_sh_q[0], craft_dtr_i};
            if (hb_edge)
                peer_to_q <= 32'h0000_0000;
            else if (!peer_lost)
                peer_to_q <= peer_to_q + 32'h0000_0001;
        end
    end

    // role: timeout well below the switch budget
    always @(posedge clk_i) begin
        if (rst_i) begin
            role_active_o <= 1'b0;
            heartbeat_o   <= 1'b0;
        end else begin
            if (win_end)
                heartbeat_o <= ~heartbeat_o;
            if (ctrl_q[`CCS_B_FSTBY])
                role_active_o <= 1'b0;
            else if (peer_lost)
                role_active_o <= 1'b1;
            else if (pact_sh_q[1] && role_active_o && !pref_sh_q[1])
                role_active_o <= 1'b0;
            else if (!pact_sh_q[1] && pref_sh_q[1])
                role_active_o <= 1'b1;
        end
    end

    // indicators and alarm
    wire [2:0] col_a = ccs_colour(supply_a_mv_i, lo_thr, hi_thr,
                                  elo_thr, ehi_thr, two_col);
    wire [2:0] col_b = ccs_colour(supply_b_mv_i, lo_thr, hi_thr,
                                  elo_thr, ehi_thr, two_col);
    wire       flash = ~ctrl_q[`CCS_B_BOOTDONE] | ctrl_q[`CCS_B_WRITING];
    wire [1:0] role_col = role_active_o ? `CCS_ROLE_GREEN : `CCS_ROLE_AMBER;
    always @(posedge clk_i) begin
        if (rst_i) begin
            supply_a_indicator_o <= `CCS_COL_OFF;
            supply_b_indicator_o <= `CCS_COL_OFF;
            fault_indicator_o    <= 1'b1;
            role_indicator_o     <= `CCS_ROLE_OFF;
            supply_alarm_o       <= 1'b0;
            craft_en_o           <= 1'b0;
            dcc_chan_count_o     <= 7'h00;
        end else begin
            supply_a_indicator_o <= col_a;
            supply_b_indicator_o <= col_b;
            supply_alarm_o       <= (col_a == `CCS_COL_RED) |
                                    (col_b == `CCS_COL_RED);
            fault_indicator_o    <= flash & blink_q;
            if (ctrl_q[`CCS_B_DBWR])
                role_indicator_o <= blink_q ? role_col : `CCS_ROLE_OFF;
            else
                role_indicator_o <= role_col;
            craft_en_o           <= dtr_sh_q[1];
            dcc_chan_count_o     <= dcc_q;
        end
    end

    // read mux, unmapped offsets read zero
    always @* begin
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            `CCS_OFS_CTRL:   rdata_d = ctrl_q;
            `CCS_OFS_THR_LO: rdata_d = thr_lo_q;
            `CCS_OFS_THR_HI: rdata_d = thr_hi_q;
            `CCS_OFS_STATUS: rdata_d = {8'h00, craft_en_o, ~peer_lost, ref_ok_q,
                                        1'b0, ref_sel_o, 1'b0, holdover_o,
                                        role_active_o, supply_alarm_o,
                                        1'b0, supply_b_indicator_o,
                                        1'b0, supply_a_indicator_o};
            `CCS_OFS_SUPPLY: rdata_d = {supply_b_mv_i, supply_a_mv_i};
            `CCS_OFS_TRACK:  rdata_d = {16'h0000, track_q};
            `CCS_OFS_DCC:    rdata_d = {25'h0000000, dcc_q};
            default:         rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req)
                wb_dat_o <= rdata_d;
        end
    end

endmodule // ccs_top

// file: verif/ccs_peer_model.sv
module ccs_peer_model (
    input  logic       clk_i,
    input  logic [5:0] ref_en_i,
    input  logic       hb_alive_i,
    output logic [5:0] ref_clk_o,
    output logic       peer_heartbeat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] div_q = 3'h0;
    logic [5:0] lvl_q = 6'h00;
    logic       hb_q  = 1'b0;
    // a lost source freezes at its last level, like a dead line
    assign ref_clk_o        = lvl_q;
    assign peer_heartbeat_o = hb_q;
    always @(posedge clk_i) begin
        div_q <= div_q + 3'h1;
        if (div_q[1:0] == 2'h3) begin
            lvl_q <= lvl_q ^ ref_en_i;
        end
        if (div_q == 3'h7 && hb_alive_i) begin
            hb_q <= ~hb_q;
        end
    end
endmodule // ccs_peer_model

// file: verif/ccs_top_props.sv
module ccs_top_props #(
    parameter BLINK_CYC = 8
) (
    input logic       clk_i,
    input logic       rst_i,
    input logic [2:0] supply_a_indicator_o,
    input logic [2:0] supply_b_indicator_o,
    input logic       supply_alarm_o,
    input logic       fault_indicator_o,
    input logic [1:0] role_indicator_o,
    input logic       role_active_o,
    input logic [2:0] ref_sel_o,
    input logic       holdover_o,
    input logic       craft_dtr_i,
    input logic       craft_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    wire red_any = supply_a_indicator_o[2] | supply_b_indicator_o[2];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_fault_rst; $fell(rst_i) |-> fault_indicator_o; endproperty
    a_fault_rst: assert property (p_fault_rst) else $error("fault lamp dark");
    // bound only holds with a shortened blink period
    property p_fault_fl; (BLINK_CYC < 16) && $fell(rst_i) |-> ##[1:40] !fault_indicator_o; endproperty
    a_fault_fl: assert property (p_fault_fl) else $error("fault lamp not flashing");
    property p_col_a; $past(rst_i, 2) == 1'b0 |-> $onehot(supply_a_indicator_o); endproperty
    a_col_a: assert property (p_col_a) else $error("lamp A colour");
    property p_col_b; $past(rst_i, 2) == 1'b0 |-> $onehot(supply_b_indicator_o); endproperty
    a_col_b: assert property (p_col_b) else $error("lamp B colour");
    property p_alarm; red_any |-> ##[0:1] supply_alarm_o; endproperty
    a_alarm: assert property (p_alarm) else $error("no supply alarm");
    property p_role; role_indicator_o != 2'h0 && $stable(role_active_o)
        |-> role_indicator_o == (role_active_o ? 2'h1 : 2'h2); endproperty
    a_role: assert property (p_role) else $error("role lamp colour");
    property p_hold; holdover_o |-> ref_sel_o == 3'h7; endproperty
    a_hold: assert property (p_hold) else $error("holdover off internal");
    property p_craft; craft_dtr_i [*4] |-> craft_en_o; endproperty
    a_craft: assert property (p_craft) else $error("craft port not usable");
endmodule // ccs_top_props

bind ccs_top ccs_top_props #(.BLINK_CYC(BLINK_CYC)) ccs_top_props_inst (.*);

// file: verif/ccs_top_tb.sv
`include "ccs_regs.vh"

module ccs_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] TL = `CCS_THR_LO_RST;
    localparam logic [31:0] TH = `CCS_THR_HI_RST;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, peer_heartbeat_i;
    logic        peer_active_i, slot_preferred_i, craft_dtr_i, craft_en_o, hb_alive;
    logic        fault_indicator_o, supply_alarm_o, holdover_o, role_active_o, heartbeat_o;
    logic [1:0]  role_indicator_o;
    logic [2:0]  supply_a_indicator_o, supply_b_indicator_o, ref_sel_o;
    logic [3:0]  wb_sel_i;
    logic [5:0]  ref_clk_i, ref_en;
    logic [6:0]  dcc_chan_count_o;
    logic [7:0]  wb_adr_i;
    logic [15:0] supply_a_mv_i, supply_b_mv_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    int          errors, n_checks, cyc_cnt, k, k2;
    logic [15:0] corner [8] = '{16'h9C3F, 16'h9C40, 16'hA40F, 16'hA410,
                                16'hD6D8, 16'hD6D9, 16'hE290, 16'hE291};
    logic [7:0]  dccv [4] = '{8'h7F, 8'h55, 8'h54, 8'h20};

    ccs_top #(.WIN_CYC(64), .BLINK_CYC(8), .PEER_TO_CYC(32)) ccs_top_inst (.*);
    ccs_peer_model ccs_peer_model_inst (.clk_i(clk_i), .ref_en_i(ref_en), .hb_alive_i(hb_alive),
        .ref_clk_o(ref_clk_i), .peer_heartbeat_o(peer_heartbeat_i));

    function automatic logic [2:0] exp_col(input logic [15:0] v, input logic two);
        if (v > TH[31:16] || v < TL[31:16]) return `CCS_COL_RED;
        if (two || (v >= TL[15:0] && v <= TH[15:0])) return `CCS_COL_GREEN;
        return `CCS_COL_AMBER;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // outputs read right after an edge still hold their pre-edge values
    // waits for ack with no cycle budget of its own; the run timeout ends a hang
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int lat;
        lat = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge clk_i);
            lat++;
        end while (wb_ack_o !== 1'b1);
        chk(lat, 2);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic supply(input logic [15:0] a, input logic [15:0] b, input logic two);
        @(posedge clk_i);
        supply_a_mv_i <= a;
        supply_b_mv_i <= b;
        repeat (3) @(posedge clk_i);
        chk(supply_a_indicator_o, exp_col(a, two));
        chk(supply_b_indicator_o, exp_col(b, two));
        chk(supply_alarm_o, (exp_col(a, two) | exp_col(b, two)) > 3'h3);
    endtask

    task automatic ref_step(input logic [5:0] en, input logic [2:0] sel, input logic hold);
        @(posedge clk_i);
        ref_en <= en;
        repeat (256) @(posedge clk_i);
        chk(ref_sel_o, sel);
        chk(holdover_o, hold);
    endtask

    task automatic print_verdict();
        $display("checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 4000) begin
            errors++;
            $display("Error at %0t: run hung", $time);
            print_verdict();
        end
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, slot_preferred_i, craft_dtr_i} = 5'h00;
        {rst_i, hb_alive, peer_active_i, wb_sel_i} = 7'h7F;
        {wb_adr_i, wb_dat_i, ref_en} = 46'h0;
        {supply_a_mv_i, supply_b_mv_i} = 32'hB000_B000;
        void'($urandom(88252));
        repeat (4) @(posedge clk_i);
        chk(fault_indicator_o, 1'b1);
        chk(ref_sel_o, `CCS_REF_INT);
        rst_i <= 1'b0;
        wb(1'b0, `CCS_OFS_CTRL, 32'h0);
        chk(rd, `CCS_CTRL_RST);
        wb(1'b0, 8'hFC, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        wb(1'b1, `CCS_OFS_CTRL, 32'h0000_4209);
        foreach (corner[i]) supply(corner[i], corner[7 - i], 1'b1);
        wb(1'b1, `CCS_OFS_CTRL, 32'h0000_4201);
        foreach (corner[i]) supply(corner[i], corner[(i + 3) % 8], 1'b0);
        repeat (12) begin
            k = $urandom_range(22528);
            k2 = $urandom_range(22528);
            supply(16'(k) + 16'h9000, 16'(k2) + 16'h9000, 1'b0);
        end
        $display("test supply done");
        chk(role_indicator_o, `CCS_ROLE_AMBER);
        @(posedge clk_i);
        hb_alive <= 1'b0;
        k = 0;
        while (role_active_o !== 1'b1 && k < 80) begin
            @(posedge clk_i);
            k++;
        end
        chk(k >= 20 && k <= 40, 1'b1);
        hb_alive <= 1'b1;
        peer_active_i <= 1'b0;
        slot_preferred_i <= 1'b1;
        wb(1'b1, `CCS_OFS_CTRL, 32'h0000_4207);
        k = 0;
        k2 = 0;
        repeat (32) begin
            @(posedge clk_i);
            k += fault_indicator_o;
            k2 += (role_indicator_o === `CCS_ROLE_GREEN);
        end
        chk(k, 16);
        chk(k2, 16);
        wb(1'b1, `CCS_OFS_CTRL, 32'h0000_4201);
        repeat (2) @(posedge clk_i);
        chk(fault_indicator_o, 1'b0);
        chk(role_indicator_o, `CCS_ROLE_GREEN);
        $display("test role done");
        ref_step(6'h10, 3'h4, 1'b0);
        ref_step(6'h14, 3'h2, 1'b0);
        ref_step(6'h20, 3'h7, 1'b1);
        wb(1'b1, `CCS_OFS_CTRL, 32'h0000_4501);
        ref_step(6'h20, 3'h5, 1'b0);
        $display("test timing done");
        foreach (dccv[i]) begin
            wb(1'b1, `CCS_OFS_DCC, {24'h0, dccv[i]});
            @(posedge clk_i);
            chk(dcc_chan_count_o, dccv[i] > 8'h54 ? 8'h54 : dccv[i]);
        end
        craft_dtr_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk(craft_en_o, 1'b1);
        craft_dtr_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk(craft_en_o, 1'b0);
        wb(1'b0, `CCS_OFS_STATUS, 32'h0);
        chk(rd[23:9], {2'b01, 6'h20, 1'b0, 3'h5, 2'b00, 1'b1});
        k = heartbeat_o;
        repeat (64) @(posedge clk_i);
        chk(heartbeat_o, k ^ 1);
        wb(1'b1, `CCS_OFS_CTRL, 32'h0000_4511);
        repeat (3) @(posedge clk_i);
        chk(role_indicator_o, `CCS_ROLE_AMBER);
        $display("test misc done");
        print_verdict();
    end
endmodule // ccs_top_tb
